// ===== hw/bcd_dec_alu.sv
// Combinational arithmetic for the decimal adjust and decrement operations
`timescale 1ns/1ps
module bcd_dec_alu (
  input wire logic is_adj,
  input wire logic [7:0] opnd,
  input wire logic c_in,
  input wire logic dig_in,
  output logic [7:0] result,
  output logic c_out,
  output logic dig_out,
  output logic z_out,
  output logic vf_out,
  output logic n_out
);
  logic lo_fix;
  logic [4:0] lo_sum;
  logic [4:0] hi_base;
  logic hi_fix;
  logic [4:0] hi_sum;
  logic [7:0] dec_res;

  assign lo_fix = (opnd[3:0] > bcd_dec_pkg::ADJ_LIMIT) | dig_in;
  assign lo_sum = {1'b0, opnd[3:0]} + (lo_fix ? {1'b0, bcd_dec_pkg::BCD_ADJ} : 5'h00);
  assign hi_base = {1'b0, opnd[7:4]} + {4'h0, lo_sum[4]};
  assign hi_fix = (hi_base > bcd_dec_pkg::ADJ_HI_LIMIT) | c_in;
  assign hi_sum = hi_base + (hi_fix ? {1'b0, bcd_dec_pkg::BCD_ADJ} : 5'h00);
  assign dec_res = opnd - bcd_dec_pkg::DEC_STEP;

  assign result = is_adj ? {hi_sum[3:0], lo_sum[3:0]} : dec_res;
  // Carry keeps an earlier decimal carry so chained digits stay correct
  assign c_out = is_adj ? (c_in | hi_sum[4]) : (opnd != 8'h00);
  assign dig_out = is_adj ? dig_in : (opnd[3:0] != 4'h0);
  assign z_out = (dec_res == 8'h00);
  assign vf_out = (opnd == bcd_dec_pkg::VF_EDGE);
  assign n_out = dec_res[7];
endmodule

// ===== hw/bcd_dec_core.sv
// APB execution unit for decimal adjust and decrement instructions
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module bcd_dec_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  bcd_dec_pkg::exec_state_t state_q, state_d;
  logic [7:0] mem [0:4095];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [15:0] instr_q;
  logic two_word_q;
  logic [7:0] acc_q;
  logic [4:0] status_q;
  logic [3:0] bank_q;
  logic ext_q;
  logic [11:0] idxb_q;
  logic [11:0] faddr_q;
  logic is_adj_q, is_dec_q, is_dsz_q, is_dsnz_q, is_ill_q;
  logic [7:0] opnd_q;
  logic [7:0] res_q;
  logic [4:0] flags_q;
  logic [2:0] nop_cnt_q;
  logic skip_q;
  logic [1:0] cyc_q;
  logic rej_q;

  // Bus decode
  wire access = psel & penable & pready_q;
  wire wr_en = access & pwrite;
  wire busy = (state_q != bcd_dec_pkg::ST_IDLE);
  wire hit = (paddr == bcd_dec_pkg::OFF_INSTR) | (paddr == bcd_dec_pkg::OFF_ACC) |
             (paddr == bcd_dec_pkg::OFF_STATUS) | (paddr == bcd_dec_pkg::OFF_BANK) |
             (paddr == bcd_dec_pkg::OFF_CTRL) | (paddr == bcd_dec_pkg::OFF_IDXB) |
             (paddr == bcd_dec_pkg::OFF_FADDR) | (paddr == bcd_dec_pkg::OFF_FDATA) |
             (paddr == bcd_dec_pkg::OFF_EXEC);
  // All registers are frozen to software while busy, whether or not execution writes them
  wire sw_ok = wr_en & ~busy;
  wire start = sw_ok & (paddr == bcd_dec_pkg::OFF_INSTR);
  wire wr_acc = sw_ok & (paddr == bcd_dec_pkg::OFF_ACC);
  wire wr_status = sw_ok & (paddr == bcd_dec_pkg::OFF_STATUS);
  wire wr_bank = sw_ok & (paddr == bcd_dec_pkg::OFF_BANK);
  wire wr_ctrl = sw_ok & (paddr == bcd_dec_pkg::OFF_CTRL);
  wire wr_idxb = sw_ok & (paddr == bcd_dec_pkg::OFF_IDXB);
  wire wr_faddr = sw_ok & (paddr == bcd_dec_pkg::OFF_FADDR);
  wire wr_fdata = sw_ok & (paddr == bcd_dec_pkg::OFF_FDATA);
  wire reject = wr_en & busy & (paddr == bcd_dec_pkg::OFF_INSTR);

  // Opcode decode
  wire dec_adj = (instr_q == bcd_dec_pkg::OP_DECADJ);
  wire dec_dec = (instr_q[15:10] == bcd_dec_pkg::PFX_DEC);
  wire dec_dsz = (instr_q[15:10] == bcd_dec_pkg::PFX_DSZ);
  wire dec_dsnz = (instr_q[15:10] == bcd_dec_pkg::PFX_DSNZ);
  wire dec_any = is_dec_q | is_dsz_q | is_dsnz_q;
  wire [7:0] f_addr = instr_q[7:0];
  wire bank_a = instr_q[bcd_dec_pkg::A_BIT];
  wire dest_d = instr_q[bcd_dec_pkg::D_BIT];

  // Operand address
  wire use_idx = ~bank_a & ext_q & (f_addr <= bcd_dec_pkg::IDX_LIMIT);
  wire [11:0] idx_addr = idxb_q + {4'h0, f_addr};
  wire [11:0] acc_bank_addr = (f_addr < bcd_dec_pkg::ACCESS_SPLIT) ?
                              {bcd_dec_pkg::ACCESS_LOW_BANK, f_addr} :
                              {bcd_dec_pkg::ACCESS_HIGH_BANK, f_addr};
  wire [11:0] eff_addr = use_idx ? idx_addr :
                         (bank_a ? {bank_q, f_addr} : acc_bank_addr);

  // Arithmetic
  logic [7:0] alu_res;
  logic alu_c, alu_dig, alu_z, alu_vf, alu_n;
  bcd_dec_alu u_alu (
    .is_adj(is_adj_q),
    .opnd(opnd_q),
    .c_in(status_q[bcd_dec_pkg::ST_C]),
    .dig_in(status_q[bcd_dec_pkg::ST_DIG]),
    .result(alu_res),
    .c_out(alu_c),
    .dig_out(alu_dig),
    .z_out(alu_z),
    .vf_out(alu_vf),
    .n_out(alu_n)
  );

  // Write-back and skip decisions in the fourth quarter
  wire in_q4 = (state_q == bcd_dec_pkg::ST_Q4);
  wire wb_acc = in_q4 & (is_adj_q | (dec_any & ~dest_d));
  wire wb_mem = in_q4 & dec_any & dest_d;
  wire skip_now = (is_dsz_q & (res_q == 8'h00)) | (is_dsnz_q & (res_q != 8'h00));
  wire [4:0] status_wb = is_adj_q ?
                         {status_q[4:1], flags_q[bcd_dec_pkg::ST_C]} : flags_q;
  wire wb_status = in_q4 & (is_adj_q | is_dec_q);

  wire [31:0] rd_mux =
    (paddr == bcd_dec_pkg::OFF_INSTR) ? {15'h0000, two_word_q, instr_q} :
    (paddr == bcd_dec_pkg::OFF_ACC) ? {24'h000000, acc_q} :
    (paddr == bcd_dec_pkg::OFF_STATUS) ? {27'h0000000, status_q} :
    (paddr == bcd_dec_pkg::OFF_BANK) ? {28'h0000000, bank_q} :
    (paddr == bcd_dec_pkg::OFF_CTRL) ? {31'h00000000, ext_q} :
    (paddr == bcd_dec_pkg::OFF_IDXB) ? {20'h00000, idxb_q} :
    (paddr == bcd_dec_pkg::OFF_FADDR) ? {20'h00000, faddr_q} :
    (paddr == bcd_dec_pkg::OFF_FDATA) ? {24'h000000, mem[faddr_q]} :
    (paddr == bcd_dec_pkg::OFF_EXEC) ? {26'h0000000, rej_q, is_ill_q, cyc_q, skip_q, busy} :
    32'h00000000;

  // Quarter sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      bcd_dec_pkg::ST_IDLE: state_d = start ? bcd_dec_pkg::ST_Q1 : bcd_dec_pkg::ST_IDLE;
      bcd_dec_pkg::ST_Q1: state_d = bcd_dec_pkg::ST_Q2;
      bcd_dec_pkg::ST_Q2: state_d = bcd_dec_pkg::ST_Q3;
      bcd_dec_pkg::ST_Q3: state_d = bcd_dec_pkg::ST_Q4;
      bcd_dec_pkg::ST_Q4: state_d = skip_now ? bcd_dec_pkg::ST_NOP : bcd_dec_pkg::ST_IDLE;
      bcd_dec_pkg::ST_NOP: state_d = (nop_cnt_q == 3'h0) ? bcd_dec_pkg::ST_IDLE :
                                     bcd_dec_pkg::ST_NOP;
      default: state_d = bcd_dec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      // One wait state gives the file memory read a full cycle
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~hit;
      if (psel & penable & ~pready_q & ~pwrite)
        prdata_q <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= bcd_dec_pkg::ST_IDLE;
      instr_q <= 16'h0000;
      two_word_q <= 1'b0;
      rej_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (start)
      begin
        instr_q <= pwdata[15:0];
        two_word_q <= pwdata[bcd_dec_pkg::INSTR_TWO_WORD_BIT];
      end
      rej_q <= reject | (rej_q & ~start);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {is_adj_q, is_dec_q, is_dsz_q, is_dsnz_q, is_ill_q} <= 5'h00;
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      flags_q <= bcd_dec_pkg::RST_STATUS;
    end
    else
    begin
      if (state_q == bcd_dec_pkg::ST_Q1)
        {is_adj_q, is_dec_q, is_dsz_q, is_dsnz_q, is_ill_q} <=
          {dec_adj, dec_dec, dec_dsz, dec_dsnz, ~(dec_adj | dec_dec | dec_dsz | dec_dsnz)};
      if (state_q == bcd_dec_pkg::ST_Q2)
        opnd_q <= is_adj_q ? acc_q : mem[eff_addr];
      if (state_q == bcd_dec_pkg::ST_Q3)
      begin
        res_q <= alu_res;
        flags_q <= {alu_n, alu_vf, alu_z, alu_dig, alu_c};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q <= bcd_dec_pkg::RST_ACC;
      status_q <= bcd_dec_pkg::RST_STATUS;
      bank_q <= bcd_dec_pkg::RST_BANK;
      ext_q <= 1'b0;
      idxb_q <= bcd_dec_pkg::RST_IDXB;
      faddr_q <= 12'h000;
    end
    else
    begin
      if (wb_acc)
        acc_q <= res_q;
      else if (wr_acc)
        acc_q <= pwdata[7:0];
      if (wb_status)
        status_q <= status_wb;
      else if (wr_status)
        status_q <= pwdata[4:0];
      if (wr_bank)
        bank_q <= pwdata[3:0];
      if (wr_ctrl)
        ext_q <= pwdata[0];
      if (wr_idxb)
        idxb_q <= pwdata[11:0];
      if (wr_faddr)
        faddr_q <= pwdata[11:0];
    end
  end

  // File memory has no reset; software loads it through the data window
  always_ff @(posedge pclk)
  begin
    if (wb_mem)
      mem[eff_addr] <= res_q;
    else if (wr_fdata)
      mem[faddr_q] <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nop_cnt_q <= 3'h0;
      skip_q <= 1'b0;
      cyc_q <= 2'h0;
    end
    else if (in_q4)
    begin
      skip_q <= skip_now;
      nop_cnt_q <= two_word_q ? bcd_dec_pkg::NOP_TWO_WORD : bcd_dec_pkg::NOP_ONE_WORD;
      cyc_q <= ~skip_now ? bcd_dec_pkg::CYC_ONE :
               (two_word_q ? bcd_dec_pkg::CYC_THREE : bcd_dec_pkg::CYC_TWO);
    end
    else if (state_q == bcd_dec_pkg::ST_NOP)
      nop_cnt_q <= nop_cnt_q - 3'h1;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_quarter_order: assert property ((state_q == bcd_dec_pkg::ST_Q1) |=>
    (state_q == bcd_dec_pkg::ST_Q2) ##1 (state_q == bcd_dec_pkg::ST_Q3) ##1 in_q4)
    else $error("quarters out of order");
  a_adj_decode: assert property ((state_q == bcd_dec_pkg::ST_Q1) && (instr_q == 16'h0007) |=> is_adj_q)
    else $error("decimal adjust not decoded");
  a_dec_decode: assert property ((state_q == bcd_dec_pkg::ST_Q1) && (instr_q[15:10] == 6'h01) |=> is_dec_q)
    else $error("decrement not decoded");
  a_adj_low_fix: assert property ((state_q == bcd_dec_pkg::ST_Q3) && is_adj_q &&
    ((opnd_q[3:0] > 4'h9) || status_q[bcd_dec_pkg::ST_DIG]) |=> res_q[3:0] == 4'($past(opnd_q[3:0]) + 4'h6))
    else $error("low nibble not adjusted by six");
  a_adj_carry: assert property (in_q4 && is_adj_q && (opnd_q[7:4] > 4'h9) |=> status_q[bcd_dec_pkg::ST_C])
    else $error("decimal overflow did not set carry");
  a_adj_only_c: assert property (in_q4 && is_adj_q |=> status_q[4:1] == $past(status_q[4:1]))
    else $error("decimal adjust touched other flags");
  a_dec_value: assert property ((state_q == bcd_dec_pkg::ST_Q3) && dec_any |=> res_q == 8'($past(opnd_q) - 8'h01))
    else $error("decrement result wrong");
  a_dec_zero: assert property (in_q4 && is_dec_q |=> status_q[bcd_dec_pkg::ST_Z] == ($past(res_q) == 8'h00))
    else $error("zero flag wrong after decrement");
  a_dest_acc: assert property (in_q4 && dec_any && !dest_d |=> acc_q == $past(res_q))
    else $error("accumulator not written");
  a_bank_reg: assert property ((state_q == bcd_dec_pkg::ST_Q2) && bank_a |-> eff_addr == {bank_q, f_addr})
    else $error("bank register not used");
  a_indexed_addr: assert property ((state_q == bcd_dec_pkg::ST_Q2) && !bank_a && ext_q && (f_addr <= 8'h5F) |->
    eff_addr == 12'(idxb_q + {4'h0, f_addr}))
    else $error("indexed address wrong");
  a_skip_zero: assert property (in_q4 && is_dsz_q && (res_q == 8'h00) |=> (state_q == bcd_dec_pkg::ST_NOP))
    else $error("zero skip missed");
  a_skip_nonzero: assert property (in_q4 && is_dsnz_q && (res_q != 8'h00) |=> (state_q == bcd_dec_pkg::ST_NOP))
    else $error("nonzero skip missed");
  a_skip_one: assert property (in_q4 && skip_now && !two_word_q |=>
    (state_q == bcd_dec_pkg::ST_NOP) [*4] ##1 (state_q == bcd_dec_pkg::ST_IDLE))
    else $error("single skip length wrong");
  a_skip_two: assert property (in_q4 && skip_now && two_word_q |=>
    (state_q == bcd_dec_pkg::ST_NOP) [*8] ##1 (state_q == bcd_dec_pkg::ST_IDLE))
    else $error("double skip length wrong");
  a_skip_flags: assert property (in_q4 && (is_dsz_q || is_dsnz_q) |=> $stable(status_q))
    else $error("skip operation changed flags");

  c_adj_run: cover property (in_q4 && is_adj_q);
  c_skip_one: cover property (in_q4 && skip_now && !two_word_q);
  c_skip_two: cover property (in_q4 && skip_now && two_word_q);
  c_indexed: cover property ((state_q == bcd_dec_pkg::ST_Q2) && use_idx && dec_any);
endmodule

// ===== hw/bcd_dec_pkg.sv
// Package with register map, opcode patterns and state codes of the execution block
package bcd_dec_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BANK = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_IDXB = 8'h14;
  localparam logic [7:0] OFF_FADDR = 8'h18;
  localparam logic [7:0] OFF_FDATA = 8'h1C;
  localparam logic [7:0] OFF_EXEC = 8'h20;

  // Status bit positions
  localparam int ST_C = 0;
  localparam int ST_DIG = 1;
  localparam int ST_Z = 2;
  localparam int ST_VF = 3;
  localparam int ST_N = 4;

  // Exec status bit positions
  localparam int EX_BUSY = 0;
  localparam int EX_SKIP = 1;
  localparam int EX_CYC_LO = 2;
  localparam int EX_ILL = 4;
  localparam int EX_REJ = 5;

  // Instruction word fields
  localparam int INSTR_TWO_WORD_BIT = 16;
  localparam int D_BIT = 9;
  localparam int A_BIT = 8;
  localparam logic [15:0] OP_DECADJ = 16'h0007;
  localparam logic [5:0] PFX_DEC = 6'h01;
  localparam logic [5:0] PFX_DSZ = 6'h0B;
  localparam logic [5:0] PFX_DSNZ = 6'h13;

  // Arithmetic constants
  localparam logic [3:0] ADJ_LIMIT = 4'h9;
  localparam logic [4:0] ADJ_HI_LIMIT = 5'h09;
  localparam logic [3:0] BCD_ADJ = 4'h6;
  localparam logic [7:0] DEC_STEP = 8'h01;
  localparam logic [7:0] VF_EDGE = 8'h80;

  // Addressing constants
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // Reset values and cycle figures
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [4:0] RST_STATUS = 5'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_IDXB = 12'h000;
  localparam logic [2:0] NOP_ONE_WORD = 3'h3;
  localparam logic [2:0] NOP_TWO_WORD = 3'h7;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_Q1 = 6'b000010,
    ST_Q2 = 6'b000100,
    ST_Q3 = 6'b001000,
    ST_Q4 = 6'b010000,
    ST_NOP = 6'b100000
  } exec_state_t;

endpackage

// ===== verification/tb.sv
// Self-checking APB testbench for the decimal adjust and decrement execution block
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int error_cnt = 0;
  int samples_checked = 0;

  always #12.5 pclk = ~pclk;

  bcd_dec_core dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until pready is sampled high; a dead slave is caught by the watchdog
  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready wait", n, 32'h2);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    logic e;
    apb_xfer(1'b1, addr, data, d, e);
  endtask

  task automatic rd(input logic [7:0] addr, output logic [31:0] data);
    logic e;
    apb_xfer(1'b0, addr, 32'h0, data, e);
  endtask

  task automatic run_instr(input logic [31:0] w);
    logic [31:0] v;
    int k;
    wr(bcd_dec_pkg::OFF_INSTR, w);
    k = 0;
    do
    begin
      rd(bcd_dec_pkg::OFF_EXEC, v);
      k++;
    end
    while (v[0] !== 1'b0 && k < 40);
    chk("exec idle", {31'h0, v[0]}, 32'h0);
  endtask

  // Presets accumulator, status and one file byte, runs one word, then reads all back
  task automatic op_case(input logic [31:0] w, input logic [7:0] acc_in, input logic [4:0] st_in,
                         input logic [11:0] fa, input logic [7:0] fin, input logic [7:0] fexp,
                         input logic [7:0] acc_exp, input logic [4:0] st_exp,
                         input logic [5:0] ex_exp);
    logic [31:0] v;
    wr(bcd_dec_pkg::OFF_STATUS, {27'h0, st_in});
    wr(bcd_dec_pkg::OFF_ACC, {24'h0, acc_in});
    wr(bcd_dec_pkg::OFF_FADDR, {20'h0, fa});
    wr(bcd_dec_pkg::OFF_FDATA, {24'h0, fin});
    run_instr(w);
    rd(bcd_dec_pkg::OFF_FDATA, v);
    chk("file byte", v, {24'h0, fexp});
    rd(bcd_dec_pkg::OFF_ACC, v);
    chk("accumulator", v, {24'h0, acc_exp});
    rd(bcd_dec_pkg::OFF_STATUS, v);
    chk("status", v, {27'h0, st_exp});
    rd(bcd_dec_pkg::OFF_EXEC, v);
    chk("exec", v, {26'h0, ex_exp});
  endtask

  task automatic t_reset_map;
    logic [31:0] v;
    logic e;
    logic [7:0] offs [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};
    foreach (offs[i])
    begin
      apb_xfer(1'b0, offs[i], 32'h0, v, e);
      chk("reset value", v, 32'h0);
      chk("mapped error", {31'h0, e}, 32'h0);
    end
    apb_xfer(1'b1, 8'h24, 32'hFFFF_FFFF, v, e);
    chk("unmapped write error", {31'h0, e}, 32'h1);
    apb_xfer(1'b0, 8'h24, 32'h0, v, e);
    chk("unmapped read error", {31'h0, e}, 32'h1);
    chk("unmapped read data", v, 32'h0);
  endtask

  // Low nibble, high nibble, carry-in and chained nibble carry; Z and N must survive
  task automatic t_adj;
    op_case(32'h0007, 8'hA5, 5'h00, 12'h000, 8'h00, 8'h00, 8'h05, 5'h01, 6'h04);
    op_case(32'h0007, 8'hCE, 5'h00, 12'h000, 8'h00, 8'h00, 8'h34, 5'h01, 6'h04);
    op_case(32'h0007, 8'h19, 5'h02, 12'h000, 8'h00, 8'h00, 8'h1F, 5'h02, 6'h04);
    op_case(32'h0007, 8'h99, 5'h14, 12'h000, 8'h00, 8'h00, 8'h99, 5'h14, 6'h04);
    op_case(32'h0007, 8'h12, 5'h01, 12'h000, 8'h00, 8'h00, 8'h72, 5'h01, 6'h04);
    op_case(32'h0007, 8'h9A, 5'h00, 12'h000, 8'h00, 8'h00, 8'h00, 5'h01, 6'h04);
  endtask

  task automatic t_dec;
    wr(bcd_dec_pkg::OFF_BANK, 32'h3);
    op_case(32'h0745, 8'h5A, 5'h1F, 12'h345, 8'h80, 8'h7F, 8'h5A, 5'h09, 6'h04);
    op_case(32'h0410, 8'h5A, 5'h18, 12'h010, 8'h01, 8'h01, 8'h00, 5'h07, 6'h04);
    op_case(32'h0690, 8'h5A, 5'h0F, 12'hF90, 8'h00, 8'hFF, 8'h5A, 5'h10, 6'h04);
  endtask

  // Indexed only up to 5Fh; 60h falls back to the access bank
  task automatic t_index;
    logic [31:0] v;
    wr(bcd_dec_pkg::OFF_CTRL, 32'h1);
    wr(bcd_dec_pkg::OFF_IDXB, 32'h200);
    wr(bcd_dec_pkg::OFF_FADDR, 32'h05F);
    wr(bcd_dec_pkg::OFF_FDATA, 32'hAA);
    wr(bcd_dec_pkg::OFF_FADDR, 32'h260);
    wr(bcd_dec_pkg::OFF_FDATA, 32'h55);
    op_case(32'h065F, 8'h00, 5'h00, 12'h25F, 8'h36, 8'h35, 8'h00, 5'h03, 6'h04);
    op_case(32'h0660, 8'h00, 5'h00, 12'h060, 8'h22, 8'h21, 8'h00, 5'h03, 6'h04);
    wr(bcd_dec_pkg::OFF_FADDR, 32'h05F);
    rd(bcd_dec_pkg::OFF_FDATA, v);
    chk("plain byte untouched", v, 32'hAA);
    wr(bcd_dec_pkg::OFF_FADDR, 32'h260);
    rd(bcd_dec_pkg::OFF_FDATA, v);
    chk("indexed byte untouched", v, 32'h55);
    wr(bcd_dec_pkg::OFF_CTRL, 32'h0);
  endtask

  task automatic t_skip;
    wr(bcd_dec_pkg::OFF_BANK, 32'h3);
    op_case(32'h2F45, 8'h5A, 5'h15, 12'h345, 8'h01, 8'h00, 8'h5A, 5'h15, 6'h0A);
    op_case(32'h12F45, 8'h5A, 5'h0A, 12'h345, 8'h01, 8'h00, 8'h5A, 5'h0A, 6'h0E);
    op_case(32'h2D45, 8'h5A, 5'h0A, 12'h345, 8'h05, 8'h05, 8'h04, 5'h0A, 6'h04);
    op_case(32'h4F45, 8'h5A, 5'h15, 12'h345, 8'h05, 8'h04, 8'h5A, 5'h15, 6'h0A);
    op_case(32'h4D45, 8'h5A, 5'h15, 12'h345, 8'h01, 8'h01, 8'h00, 5'h15, 6'h04);
    op_case(32'h14F45, 8'h5A, 5'h00, 12'h345, 8'h10, 8'h0F, 8'h5A, 5'h00, 6'h0E);
  endtask

  // Writes landing in Q4 and in the long skip that follows are dropped; an odd decimal-adjust word is illegal
  task automatic t_busy_illegal;
    logic [31:0] v;
    wr(bcd_dec_pkg::OFF_ACC, 32'h1A);
    wr(bcd_dec_pkg::OFF_FADDR, 32'h345);
    wr(bcd_dec_pkg::OFF_FDATA, 32'h01);
    wr(bcd_dec_pkg::OFF_INSTR, 32'h12F45);
    wr(bcd_dec_pkg::OFF_ACC, 32'h77);
    wr(bcd_dec_pkg::OFF_INSTR, 32'h0007);
    rd(bcd_dec_pkg::OFF_EXEC, v);
    chk("busy with reject", v & 32'h21, 32'h21);
    rd(bcd_dec_pkg::OFF_ACC, v);
    chk("busy write dropped", v, 32'h1A);
    run_instr(32'h0);
    op_case(32'h0017, 8'h1A, 5'h00, 12'h000, 8'h00, 8'h00, 8'h1A, 5'h00, 6'h14);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_adj();
    t_dec();
    t_index();
    t_skip();
    t_busy_illegal();
    finish_test();
  end

  // Whole run needs about a thousand cycles; 20000 leaves ample margin
  initial
  begin
    #500000;
    error_cnt++;
    finish_test();
  end
endmodule
